// ### vic_params.svh
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

// ****************************************
// Source orders and vectors
// ****************************************
`define VIC_NSRC        17
`define VIC_ORD_W       5
`define VIC_RSV_A       13
`define VIC_RSV_B       14
`define VIC_VEC_RESET   16'h0000
`define VIC_VEC_BASE    16'h0003
`define VIC_VEC_STEP    16'h0008
`define VIC_CCF_N       3

// ****************************************
// Register offsets
// ****************************************
`define VIC_ADDR_W      4
`define VIC_A_TCTL      4'h0
`define VIC_A_IEN       4'h1
`define VIC_A_IPRI      4'h2
`define VIC_A_XEN1      4'h3
`define VIC_A_XPRI1     4'h4
`define VIC_A_XEN2      4'h5
`define VIC_A_XPRI2     4'h6
`define VIC_A_EVST      4'h7
`define VIC_A_EVMSK     4'h8
`define VIC_A_SVC       4'h9

// ****************************************
// Field positions
// ****************************************
`define VIC_TC_EXT0     1
`define VIC_TC_TMR0     5
`define VIC_TC_EXT1     3
`define VIC_TC_TMR1     7
`define VIC_TC_MASK     8'hAA
`define VIC_IE_GLOBAL   7
`define VIC_EV_LO       0
`define VIC_EV_HI       1
`define VIC_EV_NEST     2
`define VIC_EV_MASK     8'h07

// ****************************************
// Reset values
// ****************************************
`define VIC_RST_BYTE    8'h00

`endif

// ### vic_pkg.sv
`include "vic_params.svh"

package vic_pkg;

   // ****************************************
   // Level pending flags from the peripherals
   // ****************************************
   typedef struct packed {
      logic                  serial_receive_flag;
      logic                  serial_transmit_flag;
      logic                  timer_two_high_overflow;
      logic                  timer_two_low_overflow;
      logic                  sync_transfer_done;
      logic                  sync_write_collision;
      logic                  sync_mode_fault;
      logic                  sync_receive_overrun;
      logic                  twowire_pending;
      logic                  port_match;
      logic                  conv_window_flag;
      logic                  conv_done_flag;
      logic                  counter_array_overflow;
      logic [`VIC_CCF_N-1:0] counter_channel_flag;
      logic                  comparator_fall_flag;
      logic                  comparator_rise_flag;
      logic                  sense_done_flag;
      logic                  sense_greater_flag;
   } vic_flags_t;

   // ****************************************
   // Set pulses for timer control flags
   // ****************************************
   typedef struct packed {
      logic ext_zero;
      logic timer_zero;
      logic ext_one;
      logic timer_one;
   } vic_tc_set_t;

   // ****************************************
   // Register port request
   // ****************************************
   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic [`VIC_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } vic_bus_req_t;

   // ****************************************
   // Service nesting state
   // ****************************************
   typedef enum logic [1:0] {
      VIC_IDLE   = 2'b00,
      VIC_LOW    = 2'b01,
      VIC_HI_LOW = 2'b11,
      VIC_HIGH   = 2'b10
   } vic_svc_t;

endpackage

// ### vic_src_gate.sv
module vic_src_gate #(
   parameter bit RESERVED = 1'b0
) (
   // Source state
   input  wire logic i_pending,
   input  wire logic i_enable,
   input  wire logic i_prio,
   input  wire logic i_global,
   // Requests
   output logic      o_req_hi,
   output logic      o_req_lo
);

   logic live;

   assign live     = !RESERVED && i_pending && i_enable && i_global;
   assign o_req_hi = live && i_prio;
   assign o_req_lo = live && !i_prio;

endmodule

// ### vic_top.sv
// What this block does
// - Reset vectors to 0x0000, unmaskable, outranks every source.
// - Pin zero: vector 0x0003, order 0, hardware-cleared flag, enable/priority bit 0.
// - Timer zero overflow: 0x000B, order 1, control bit 5, enable/priority bit 1.
// - Pin one: 0x0013, order 2, control bit 3, enable/priority bit 2.
// - Timer one overflow: 0x001B, order 3, control bit 7, enable/priority bit 3.
// - Serial port: 0x0023, order 4, receive or transmit flag, bit 4.
// - Timer two: 0x002B, order 5, high or low overflow, bit 5.
// - Sync serial: 0x0033, order 6, any of four flags, bit 6.
// - Two-wire bus: 0x003B, order 7, extended enable/priority 1 bit 0.
// - Port match: 0x0043, order 8, extended bit 1, no own flag.
// - Converter window: 0x004B, order 9, extended register 1 bit 2.
// - Converter done: 0x0053, order 10, extended register 1 bit 3.
// - Counter array: 0x005B, order 11, overflow or channel flag, bit 4.
// - Comparator: 0x0063, order 12, fall or rise flag, bit 5.
// - Sense done: 0x007B, order 15, extended register 2 bit 0.
// - Sense greater: 0x0083, order 16, extended register 2 bit 1.
//
// The strobed register port and the register addresses were left to the implementer.
`include "vic_params.svh"

module vic_top
   import vic_pkg::*;
(
   // Clock and reset
   input  wire logic          i_core_clk,
   input  wire logic          i_arst_n,
   // Register port
   input  wire vic_bus_req_t  i_bus,
   output logic [7:0]         o_rdata,
   // Peripheral flags
   input  wire vic_flags_t    i_flags,
   input  wire vic_tc_set_t   i_tc_set,
   // Processor core
   input  wire logic          i_ack,
   input  wire logic          i_reti,
   output logic               o_irq_req,
   output logic [15:0]        o_vector,
   // Timer control flags for the timers
   output logic [7:0]         o_tctl,
   // Event interrupt
   output logic               o_evt_irq
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0]               tctl_r;
   logic [7:0]               tctl_nxt;
   logic [7:0]               ien_r;
   logic [7:0]               ipri_r;
   logic [7:0]               xen1_r;
   logic [7:0]               xpri1_r;
   logic [7:0]               xen2_r;
   logic [7:0]               xpri2_r;
   logic [7:0]               evst_r;
   logic [7:0]               evst_nxt;
   logic [7:0]               evmsk_r;
   logic [7:0]               rdata_nxt;
   logic [7:0]               rdata_r;
   vic_svc_t                 svc_r;
   vic_svc_t                 svc_nxt;
   logic [`VIC_NSRC-1:0]     pend;
   logic [`VIC_NSRC-1:0]     en;
   logic [`VIC_NSRC-1:0]     pri;
   logic [`VIC_NSRC-1:0]     req_hi;
   logic [`VIC_NSRC-1:0]     req_lo;
   logic                     any_hi;
   logic                     any_lo;
   logic [`VIC_ORD_W-1:0]    ord_hi;
   logic [`VIC_ORD_W-1:0]    ord_lo;
   logic                     take_hi;
   logic                     take_lo;
   logic [`VIC_ORD_W-1:0]    ord_sel;
   logic                     req_nxt;
   logic                     req_r;
   logic                     sel_hi_r;
   logic [`VIC_ORD_W-1:0]    ord_r;
   logic [15:0]              vec_r;
   logic [15:0]              vec_nxt;
   logic                     took;
   logic                     wr_hit;
   logic                     rd_evst;

   // ****************************************
   // Pending vector by natural order
   // ****************************************
   always_comb begin
      pend      = '0;
      pend[0]   = tctl_r[`VIC_TC_EXT0];
      pend[1]   = tctl_r[`VIC_TC_TMR0];
      pend[2]   = tctl_r[`VIC_TC_EXT1];
      pend[3]   = tctl_r[`VIC_TC_TMR1];
      pend[4]   = i_flags.serial_receive_flag
                | i_flags.serial_transmit_flag;
      pend[5]   = i_flags.timer_two_high_overflow
                | i_flags.timer_two_low_overflow;
      pend[6]   = i_flags.sync_transfer_done
                | i_flags.sync_write_collision
                | i_flags.sync_mode_fault
                | i_flags.sync_receive_overrun;
      pend[7]   = i_flags.twowire_pending;
      pend[8]   = i_flags.port_match;
      pend[9]   = i_flags.conv_window_flag;
      pend[10]  = i_flags.conv_done_flag;
      pend[11]  = i_flags.counter_array_overflow
                | (|i_flags.counter_channel_flag);
      pend[12]  = i_flags.comparator_fall_flag
                | i_flags.comparator_rise_flag;
      pend[15]  = i_flags.sense_done_flag;
      pend[16]  = i_flags.sense_greater_flag;
   end

   // ****************************************
   // Enable and priority bit mapping
   // ****************************************
   always_comb begin
      en         = '0;
      pri        = '0;
      en[6:0]    = ien_r[6:0];
      pri[6:0]   = ipri_r[6:0];
      en[12:7]   = xen1_r[5:0];
      pri[12:7]  = xpri1_r[5:0];
      en[16:15]  = xen2_r[1:0];
      pri[16:15] = xpri2_r[1:0];
   end

   // ****************************************
   // Per-source gating
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `VIC_NSRC; g = g + 1) begin : g_src
         vic_src_gate #(
            .RESERVED ((g == `VIC_RSV_A) || (g == `VIC_RSV_B))
         ) u_gate (
            .i_pending (pend[g]),
            .i_enable  (en[g]),
            .i_prio    (pri[g]),
            .i_global  (ien_r[`VIC_IE_GLOBAL]),
            .o_req_hi  (req_hi[g]),
            .o_req_lo  (req_lo[g])
         );
      end
   endgenerate

   // ****************************************
   // Lowest order wins within a level
   // ****************************************
   always_comb begin
      any_hi = 1'b0;
      any_lo = 1'b0;
      ord_hi = '0;
      ord_lo = '0;
      for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
         if (req_hi[i]) begin
            any_hi = 1'b1;
            ord_hi = `VIC_ORD_W'(i);
         end
         if (req_lo[i]) begin
            any_lo = 1'b1;
            ord_lo = `VIC_ORD_W'(i);
         end
      end
   end

   // ****************************************
   // Preemption decision
   // ****************************************
   always_comb begin
      take_hi = any_hi && (svc_r == VIC_IDLE || svc_r == VIC_LOW);
      take_lo = !take_hi && any_lo && (svc_r == VIC_IDLE);
      ord_sel = take_hi ? ord_hi : ord_lo;
      req_nxt = (take_hi || take_lo) && !took;
      vec_nxt = `VIC_VEC_BASE + 16'(ord_sel) * `VIC_VEC_STEP;
   end

   assign took = i_ack && req_r;

   // ****************************************
   // Request and vector registers
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_r    <= 1'b0;
         sel_hi_r <= 1'b0;
         ord_r    <= '0;
         vec_r    <= `VIC_VEC_RESET;
      end else begin
         req_r    <= req_nxt;
         sel_hi_r <= take_hi;
         ord_r    <= ord_sel;
         if (req_nxt) begin
            vec_r <= vec_nxt;
         end
      end
   end

   // ****************************************
   // Service nesting
   // ****************************************
   always_comb begin
      svc_nxt = svc_r;
      if (took) begin
         case (svc_r)
            VIC_IDLE: begin
               svc_nxt = sel_hi_r ? VIC_HIGH : VIC_LOW;
            end
            VIC_LOW: begin
               svc_nxt = VIC_HI_LOW;
            end
            default: begin
               svc_nxt = svc_r;
            end
         endcase
      end else if (i_reti) begin
         case (svc_r)
            VIC_HIGH:   svc_nxt = VIC_IDLE;
            VIC_HI_LOW: svc_nxt = VIC_LOW;
            VIC_LOW:    svc_nxt = VIC_IDLE;
            default:    svc_nxt = VIC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         svc_r <= VIC_IDLE;
      end else begin
         svc_r <= svc_nxt;
      end
   end

   // ****************************************
   // Timer control flags
   // ****************************************
   assign wr_hit = i_bus.wr && (i_bus.addr == `VIC_A_TCTL);

   always_comb begin
      tctl_nxt = tctl_r;
      if (wr_hit) begin
         tctl_nxt = i_bus.wdata & `VIC_TC_MASK;
      end
      if (took && (ord_r < `VIC_ORD_W'(4))) begin
         case (ord_r)
            `VIC_ORD_W'(0): tctl_nxt[`VIC_TC_EXT0] = 1'b0;
            `VIC_ORD_W'(1): tctl_nxt[`VIC_TC_TMR0] = 1'b0;
            `VIC_ORD_W'(2): tctl_nxt[`VIC_TC_EXT1] = 1'b0;
            `VIC_ORD_W'(3): tctl_nxt[`VIC_TC_TMR1] = 1'b0;
            default:        tctl_nxt = tctl_nxt;
         endcase
      end
      // Set pulses win over any clear
      if (i_tc_set.ext_zero) begin
         tctl_nxt[`VIC_TC_EXT0] = 1'b1;
      end
      if (i_tc_set.timer_zero) begin
         tctl_nxt[`VIC_TC_TMR0] = 1'b1;
      end
      if (i_tc_set.ext_one) begin
         tctl_nxt[`VIC_TC_EXT1] = 1'b1;
      end
      if (i_tc_set.timer_one) begin
         tctl_nxt[`VIC_TC_TMR1] = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tctl_r <= `VIC_RST_BYTE;
      end else begin
         tctl_r <= tctl_nxt;
      end
   end

   // ****************************************
   // Enable and priority registers
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ien_r   <= `VIC_RST_BYTE;
         ipri_r  <= `VIC_RST_BYTE;
         xen1_r  <= `VIC_RST_BYTE;
         xpri1_r <= `VIC_RST_BYTE;
         xen2_r  <= `VIC_RST_BYTE;
         xpri2_r <= `VIC_RST_BYTE;
         evmsk_r <= `VIC_RST_BYTE;
      end else if (i_bus.wr) begin
         case (i_bus.addr)
            `VIC_A_IEN:   ien_r   <= i_bus.wdata;
            `VIC_A_IPRI:  ipri_r  <= {1'b0, i_bus.wdata[6:0]};
            `VIC_A_XEN1:  xen1_r  <= {2'b00, i_bus.wdata[5:0]};
            `VIC_A_XPRI1: xpri1_r <= {2'b00, i_bus.wdata[5:0]};
            `VIC_A_XEN2:  xen2_r  <= {6'b00_0000, i_bus.wdata[1:0]};
            `VIC_A_XPRI2: xpri2_r <= {6'b00_0000, i_bus.wdata[1:0]};
            `VIC_A_EVMSK: evmsk_r <= i_bus.wdata & `VIC_EV_MASK;
            default:      ien_r   <= ien_r;
         endcase
      end
   end

   // ****************************************
   // Event status, cleared by read
   // ****************************************
   assign rd_evst = i_bus.rd && (i_bus.addr == `VIC_A_EVST);

   always_comb begin
      evst_nxt = rd_evst ? `VIC_RST_BYTE : evst_r;
      if (took && !sel_hi_r) begin
         evst_nxt[`VIC_EV_LO] = 1'b1;
      end
      if (took && sel_hi_r) begin
         evst_nxt[`VIC_EV_HI] = 1'b1;
      end
      if (took && sel_hi_r && svc_r == VIC_LOW) begin
         evst_nxt[`VIC_EV_NEST] = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         evst_r <= `VIC_RST_BYTE;
      end else begin
         evst_r <= evst_nxt;
      end
   end

   // ****************************************
   // Read data, one cycle after the strobe
   // ****************************************
   always_comb begin
      rdata_nxt = `VIC_RST_BYTE;
      if (i_bus.rd) begin
         case (i_bus.addr)
            `VIC_A_TCTL:  rdata_nxt = tctl_r;
            `VIC_A_IEN:   rdata_nxt = ien_r;
            `VIC_A_IPRI:  rdata_nxt = ipri_r;
            `VIC_A_XEN1:  rdata_nxt = xen1_r;
            `VIC_A_XPRI1: rdata_nxt = xpri1_r;
            `VIC_A_XEN2:  rdata_nxt = xen2_r;
            `VIC_A_XPRI2: rdata_nxt = xpri2_r;
            `VIC_A_EVST:  rdata_nxt = evst_r;
            `VIC_A_EVMSK: rdata_nxt = evmsk_r;
            `VIC_A_SVC:   rdata_nxt = {1'b0, req_r, svc_r, 4'h0} | {3'b000, ord_r};
            default:      rdata_nxt = `VIC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= `VIC_RST_BYTE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_rdata   = rdata_r;
   assign o_irq_req = req_r;
   assign o_vector  = vec_r;
   assign o_tctl    = tctl_r;
   assign o_evt_irq = |(evst_r & evmsk_r);

endmodule

// ### vic_core_model.sv
module vic_core_model (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // Block side
   input  wire logic        i_irq_req,
   input  wire logic [15:0] i_vector,
   output logic             o_ack,
   output logic             o_reti,
   // Bench control
   input  wire logic [1:0]  i_delay,
   input  wire logic        i_hold,
   input  wire logic        i_ret_cmd,
   output logic [15:0]      o_last_vec,
   output logic [7:0]       o_taken
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] wait_r;

   // ******
   // Core taking vectors
   // ******
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ack      <= 1'b0;
         o_reti     <= 1'b0;
         wait_r     <= 2'h0;
         o_last_vec <= 16'h0000;
         o_taken    <= 8'h00;
      end else begin
         o_ack  <= 1'b0;
         o_reti <= i_ret_cmd;
         wait_r <= 2'h0;
         // Vector latched on the edge that takes it
         if (o_ack && i_irq_req) begin
            o_last_vec <= i_vector;
            o_taken    <= o_taken + 8'h01;
         end
         // Slow answers wait a few cycles
         if (i_irq_req && !o_ack && !i_hold) begin
            o_ack  <= (wait_r == i_delay);
            wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule

// ### vic_top_asserts.sv
module vic_chk
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic         i_core_clk,
   input wire logic         i_arst_n,
   // Watched ports
   input wire vic_bus_req_t i_bus,
   input wire vic_flags_t   i_flags,
   input wire vic_tc_set_t  i_tc_set,
   input wire logic         i_ack,
   input wire logic         i_reti,
   input wire logic         o_irq_req,
   input wire logic [15:0]  o_vector,
   input wire logic [7:0]   o_tctl,
   input wire logic         o_evt_irq
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   // ******
   // Checks
   // ******
   a_vector_form: assert property (
      o_irq_req |-> o_vector[2:0] == 3'h3 && o_vector[15:3] <= 13'h0010
         && o_vector[15:3] != 13'h000D && o_vector[15:3] != 13'h000E)
      else $error("request carries a vector off the grid");
   a_ack_drops: assert property (o_irq_req && i_ack |=> !o_irq_req)
      else $error("request stayed up after acknowledge");
   a_ext0_set: assert property (i_tc_set.ext_zero |=> o_tctl[1])
      else $error("pin zero flag not set");
   a_tmr0_set: assert property (i_tc_set.timer_zero |=> o_tctl[5])
      else $error("timer zero flag not set");
   a_ext1_set: assert property (i_tc_set.ext_one |=> o_tctl[3])
      else $error("pin one flag not set");
   a_tmr1_set: assert property (i_tc_set.timer_one |=> o_tctl[7])
      else $error("timer one flag not set");
   a_ext0_clear: assert property (
      o_irq_req && i_ack && o_vector == 16'h0003 && !i_tc_set.ext_zero && !i_bus.wr
      |=> !o_tctl[1]) else $error("pin zero flag kept after vectoring");
   a_tmr1_clear: assert property (
      o_irq_req && i_ack && o_vector == 16'h001B && !i_tc_set.timer_one && !i_bus.wr
      |=> !o_tctl[7]) else $error("timer one flag kept after vectoring");
   a_no_source: assert property (
      (i_flags == '0 && o_tctl == 8'h00) [*2] |=> !o_irq_req)
      else $error("request without any pending flag");

   c_sense_greater: cover property (o_irq_req && i_ack && o_vector == 16'h0083);
   c_event_irq: cover property (o_evt_irq);
   c_return: cover property (i_reti && !o_irq_req);
endmodule

bind vic_top vic_chk u_vic_chk (
   .i_core_clk (i_core_clk),
   .i_arst_n   (i_arst_n),
   .i_bus      (i_bus),
   .i_flags    (i_flags),
   .i_tc_set   (i_tc_set),
   .i_ack      (i_ack),
   .i_reti     (i_reti),
   .o_irq_req  (o_irq_req),
   .o_vector   (o_vector),
   .o_tctl     (o_tctl),
   .o_evt_irq  (o_evt_irq)
);

// ### test_vectored_interrupt_controller.sv
`include "vic_params.svh"

module test_vectored_interrupt_controller import vic_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic         clk     = 1'b0;
   logic         rst_n   = 1'b0;
   vic_bus_req_t bus     = '0;
   vic_flags_t   flags   = '0;
   vic_tc_set_t  tc      = '0;
   logic [1:0]   dly     = 2'h0;
   logic         hold    = 1'b0;
   logic         ret_cmd = 1'b0;
   logic [7:0]   nexp    = 8'h00;
   logic         ack, reti, req, evt;
   logic [7:0]   rdata, tctl, taken;
   logic [15:0]  vec, last_vec;
   int           n_fail    = 0;
   int           tests_run = 0;

   initial begin
      forever #25 clk = ~clk;
   end

   vic_top uut (.i_core_clk(clk), .i_arst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_flags(flags), .i_tc_set(tc), .i_ack(ack), .i_reti(reti), .o_irq_req(req),
      .o_vector(vec), .o_tctl(tctl), .o_evt_irq(evt));

   vic_core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_req(req), .i_vector(vec),
      .o_ack(ack), .o_reti(reti), .i_delay(dly), .i_hold(hold), .i_ret_cmd(ret_cmd),
      .o_last_vec(last_vec), .o_taken(taken));

   // ******
   // Shared tasks
   // ******
   task automatic check(input logic [15:0] s, input logic [15:0] e, input string w);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t ns: %s seen %h expected %h", $time, w, s, e);
      end
   endtask

   task automatic give_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string w);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      check({8'h00, rdata}, {8'h00, e}, w);
   endtask

   function automatic logic [23:0] bitof(input int o);
      return 24'h00_0001 << ((o < 7) ? o : o + 1);
   endfunction

   task automatic set_masks(input logic [23:0] en, input logic [23:0] pr);
      bus_wr(`VIC_A_IEN, {1'b1, en[6:0]});
      bus_wr(`VIC_A_IPRI, {1'b0, pr[6:0]});
      bus_wr(`VIC_A_XEN1, en[15:8]);
      bus_wr(`VIC_A_XPRI1, pr[15:8]);
      bus_wr(`VIC_A_XEN2, en[23:16]);
      bus_wr(`VIC_A_XPRI2, pr[23:16]);
   endtask

   task automatic set_src(input int o, input int alt, input logic v);
      int idx;
      case (o)
         4:       idx = 19 - alt % 2;
         5:       idx = 17 - alt % 2;
         6:       idx = 15 - alt;
         11:      idx = 7 - alt;
         12:      idx = 3 - alt % 2;
         15, 16:  idx = 16 - o;
         default: idx = 18 - o;
      endcase
      @(posedge clk);
      if (o < 4) begin
         tc[3 - o] <= v;
         @(posedge clk);
         tc <= '0;
      end else begin
         flags[idx] <= v;
      end
   endtask

   task automatic take(input logic [15:0] v);
      int k;
      k = 0;
      nexp = nexp + 8'h01;
      while (taken !== nexp && k < 40) begin
         @(posedge clk);
         k++;
      end
      @(negedge clk);
      check({8'h00, taken}, {8'h00, nexp}, "services");
      check(last_vec, v, "vector");
   endtask

   task automatic quiet();
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({8'h00, taken}, {8'h00, nexp}, "refused");
   endtask

   task automatic ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
   endtask

   // ******
   // Scenarios
   // ******
   task automatic test_reset();
      check({15'h0000, req}, 16'h0000, "request");
      check(vec, `VIC_VEC_RESET, "reset vector");
      for (int a = 0; a < 16; a++)
         rd_chk(4'(a), 8'h00, "reset value");
   endtask

   task automatic test_regs();
      logic [3:0] ad[7];
      logic [7:0] ex[7];
      ad = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hF};
      ex = '{8'hAA, 8'h7F, 8'h3F, 8'h3F, 8'h03, 8'h03, 8'h00};
      foreach (ad[i]) begin
         bus_wr(ad[i], 8'hFF);
         rd_chk(ad[i], ex[i], "readback");
         bus_wr(ad[i], 8'h00);
      end
   endtask

   task automatic test_sources();
      int         ords[15];
      int         na;
      logic [15:0] ve;
      ords = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 15, 16};
      foreach (ords[i]) begin
         na = (ords[i] == 6 || ords[i] == 11) ? 4 : (ords[i] inside {4, 5, 12}) ? 2 : 1;
         ve = 16'h0003 + 16'(8 * ords[i]);
         for (int a = 0; a < na; a++) begin
            dly <= 2'(ords[i] % 3);
            set_masks(bitof(ords[i]), 24'h00_0000);
            set_src(ords[i], a, 1'b1);
            take(ve); // to
            if (ords[i] < 4) begin
               check({8'h00, tctl}, 16'h0000, "flag cleared");
               ret();
            end else begin
               ret();
               take(ve);
               set_src(ords[i], a, 1'b0);
               ret();
            end
            quiet();
         end
      end
   endtask

   task automatic test_prio();
      bus_wr(`VIC_A_EVMSK, 8'h00);
      rd_chk(`VIC_A_EVST, 8'h01, "old events");
      set_masks(bitof(0) | bitof(3) | bitof(5) | bitof(9) | bitof(16), bitof(5) | bitof(16));
      @(posedge clk);
      hold <= 1'b1;
      set_src(3, 0, 1'b1);
      set_src(9, 0, 1'b1);
      set_src(0, 0, 1'b1);
      set_src(16, 0, 1'b1);
      @(posedge clk);
      hold <= 1'b0;
      take(16'h0083);
      check({15'h0000, evt}, 16'h0000, "masked event");
      bus_wr(`VIC_A_EVMSK, 8'h07);
      @(negedge clk);
      check({15'h0000, evt}, 16'h0001, "event raised");
      rd_chk(`VIC_A_EVST, 8'h02, "event status");
      check({15'h0000, evt}, 16'h0000, "event cleared");
      set_src(5, 0, 1'b1);
      quiet();
      set_src(16, 0, 1'b0);
      ret();
      take(16'h002B);
      set_src(5, 0, 1'b0);
      ret();
      take(16'h0003);
      set_src(16, 0, 1'b1);
      take(16'h0083);
      rd_chk(`VIC_A_EVST, 8'h07, "nested status");
      set_src(16, 0, 1'b0);
      ret();
      quiet();
      ret();
      take(16'h001B);
      ret();
      take(16'h004B);
      set_src(9, 0, 1'b0);
      ret();
      quiet();
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      test_reset();
      test_regs();
      test_sources();
      test_prio();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule
